/* src/tre_cfg.svh */
`ifndef TRE_CFG_SVH
`define TRE_CFG_SVH

// ----------------------------------------------------------------------
// clock and symbol timing
// ----------------------------------------------------------------------
`define TRE_CLK_HZ        25000000
`define TRE_CLK_PERIOD_NS 40
`define TRE_OSC_HZ        70000
`define TRE_OSC_DIV       (`TRE_CLK_HZ / `TRE_OSC_HZ)
`define TRE_SETTLE_NS     10000
`define TRE_SETTLE_CYC    ((`TRE_SETTLE_NS + `TRE_CLK_PERIOD_NS - 1) / `TRE_CLK_PERIOD_NS)
`define TRE_LAG_MS        150
`define TRE_LAG_CYC       (`TRE_LAG_MS * (`TRE_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// packet layout
// ----------------------------------------------------------------------
`define TRE_ADDR_BITS     10
`define TRE_DATA_BITS     8
`define TRE_SYM_COUNT     18
`define TRE_WORDS         3
`define TRE_BUF_DEPTH     2

// ----------------------------------------------------------------------
// symbol pulse patterns, eight oscillator ticks each, msb first
// ----------------------------------------------------------------------
`define TRE_PAT_LOW       8'h88
`define TRE_PAT_HIGH      8'hEE
`define TRE_PAT_FLOAT     8'h8E
`define TRE_PAT_SYNC      8'hF0

`endif

/* src/tre_pkg.sv */
package tre_pkg;

    // symbol kinds carried through the buffer
    typedef enum logic [1:0]
    {
        TRE_SYM_LOW   = 2'h0,
        TRE_SYM_HIGH  = 2'h1,
        TRE_SYM_SYNC  = 2'h2,
        TRE_SYM_FLOAT = 2'h3
    } tre_sym_e;

    // encoder sequence, gray along the usual path
    typedef enum logic [2:0]
    {
        TRE_ST_IDLE  = 3'h0,
        TRE_ST_SENSH = 3'h1,
        TRE_ST_SENSL = 3'h3,
        TRE_ST_SEND  = 3'h2,
        TRE_ST_DRAIN = 3'h6
    } tre_state_e;

endpackage

/* src/tre_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none

// valid/ready symbol stream between encoder parts
interface tre_stream_if;
    logic               valid;
    logic               ready;
    tre_pkg::tre_sym_e  data;

    modport src
    (
        output valid,
        output data,
        input  ready
    );
    modport snk
    (
        input  valid,
        input  data,
        output ready
    );
endinterface

`default_nettype wire

/* src/tre_sym_buf.sv */
`timescale 1ns/100ps
`default_nettype none

// two-entry symbol buffer; a stalled serialiser back-pressures the sequencer
module tre_sym_buf #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    // filling side
    tre_stream_if.snk  in_s,
    // draining side
    tre_stream_if.src  out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    tre_pkg::tre_sym_e  mem_q [DEPTH];
    tre_pkg::tre_sym_e  mem_d [DEPTH];
    logic [PW-1:0]      wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]        cnt_q, cnt_d;
    logic               push, pop;

    // ----------------------------------------------------------------------
    // handshakes and pointers
    // ----------------------------------------------------------------------
    assign in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_comb
    begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_s.data;
            wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
            rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        // simultaneous push and pop leaves the fill level unchanged
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= tre_pkg::TRE_SYM_LOW;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_buf_no_overfill: assert property (cnt_q <= (PW+1)'(DEPTH))
        else $error("symbol buffer fill level above depth");

endmodule

`default_nettype wire

/* src/tre_encoder.sv */
// What this block does
// - trigger high starts three-packet cycle
// - cycles repeat while trigger stays high
// - trigger low: finish cycle, then stop
// - order: address 0..9, then data 0..7
// - each line sensed high, low or floating
// - data lines captured when trigger rises
// - lines resampled at each cycle start
// - data change appears within 150 ms
// - ten tri-state address lines, 59049 codes
// - one serial stream drives radio keying
// - symbol timing from 70 kHz oscillator
// - serial output high about a quarter to three quarters of time, by line levels
`timescale 1ns/100ps
`default_nettype none
`include "tre_cfg.svh"

module tre_encoder #(
    parameter int LAG_CYC = `TRE_LAG_CYC
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    // trigger and tri-state line pins
    input  wire logic                      transmit_trigger_line,
    input  wire logic [`TRE_ADDR_BITS-1:0] pairing_code_inputs,
    input  wire logic [`TRE_DATA_BITS-1:0] payload_inputs,
    // weak bias applied to all lines while sensing
    output logic                           sense_bias,
    // keying output to the radio stage
    output logic                           serial_mod_out
);
    localparam int NS = `TRE_SYM_COUNT;
    localparam int NL = `TRE_ADDR_BITS + `TRE_DATA_BITS;

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    logic [NL:0] meta_q, sync_q;
    logic        trig_s;
    logic [NL-1:0] lines_s;

    // data lines follow address lines so bit index equals symbol index
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= {transmit_trigger_line, payload_inputs, pairing_code_inputs};
            sync_q <= meta_q;
        end
    end
    assign trig_s  = sync_q[NL];
    assign lines_s = sync_q[NL-1:0];

    // ----------------------------------------------------------------------
    // oscillator tick divider
    // ----------------------------------------------------------------------
    logic [8:0] div_q, div_d;
    logic       tick;

    // one enable pulse per oscillator period
    always_comb
    begin
        tick  = (div_q == 9'(`TRE_OSC_DIV - 1));
        div_d = tick ? 9'h000 : div_q + 9'h001;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            div_q <= 9'h000;
        else
            div_q <= div_d;
    end

    // ----------------------------------------------------------------------
    // sequencer: sense lines, emit symbols, count words
    // ----------------------------------------------------------------------
    tre_stream_if push_if ();
    tre_stream_if pop_if ();

    tre_pkg::tre_state_e            st_q, st_d;
    logic [7:0]                     wait_q, wait_d;
    logic [NL-1:0]                  hi_q, hi_d;
    tre_pkg::tre_sym_e [NS-1:0]     sym_q, sym_d;
    logic [4:0]                     idx_q, idx_d;
    logic [1:0]                     word_q, word_d;
    logic                           bias_q, bias_d;
    logic                           last_push;
    logic                           ser_idle;

    assign push_if.valid = (st_q == tre_pkg::TRE_ST_SEND);
    assign push_if.data  = (idx_q == 5'(NS)) ? tre_pkg::TRE_SYM_SYNC : sym_q[idx_q];
    assign last_push     = push_if.valid && push_if.ready && (idx_q == 5'(NS))
                           && (word_q == 2'(`TRE_WORDS - 1));

    // bias high then low: a line that follows the bias is floating
    always_comb
    begin
        st_d   = st_q;
        wait_d = wait_q;
        hi_d   = hi_q;
        sym_d  = sym_q;
        idx_d  = idx_q;
        word_d = word_q;
        bias_d = bias_q;
        unique case (st_q)
            tre_pkg::TRE_ST_IDLE:
            begin
                if (trig_s)
                begin
                    st_d   = tre_pkg::TRE_ST_SENSH;
                    bias_d = 1'b1;
                    wait_d = '0;
                end
            end
            tre_pkg::TRE_ST_SENSH:
            begin
                wait_d = wait_q + 8'h01;
                if (wait_q == 8'(`TRE_SETTLE_CYC - 1))
                begin
                    hi_d   = lines_s;
                    bias_d = 1'b0;
                    wait_d = '0;
                    st_d   = tre_pkg::TRE_ST_SENSL;
                end
            end
            tre_pkg::TRE_ST_SENSL:
            begin
                wait_d = wait_q + 8'h01;
                if (wait_q == 8'(`TRE_SETTLE_CYC - 1))
                begin
                    // three-way classification per line
                    for (int i = 0; i < NL; i++)
                    begin
                        if (hi_q[i] != lines_s[i])
                            sym_d[i] = tre_pkg::TRE_SYM_FLOAT;
                        else if (lines_s[i])
                            sym_d[i] = tre_pkg::TRE_SYM_HIGH;
                        else
                            sym_d[i] = tre_pkg::TRE_SYM_LOW;
                    end
                    idx_d  = '0;
                    word_d = '0;
                    st_d   = tre_pkg::TRE_ST_SEND;
                end
            end
            tre_pkg::TRE_ST_SEND:
            begin
                if (push_if.ready)
                begin
                    if (idx_q != 5'(NS))
                        idx_d = idx_q + 5'h01;
                    else
                    begin
                        idx_d  = '0;
                        word_d = word_q + 2'h1;
                        if (last_push)
                        begin
                            // resample at once, while the buffer still drains
                            st_d   = trig_s ? tre_pkg::TRE_ST_SENSH
                                            : tre_pkg::TRE_ST_DRAIN;
                            bias_d = trig_s;
                            wait_d = '0;
                        end
                    end
                end
            end
            tre_pkg::TRE_ST_DRAIN:
            begin
                if (ser_idle)
                    st_d = tre_pkg::TRE_ST_IDLE;
            end
            default:
                st_d = tre_pkg::TRE_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q   <= tre_pkg::TRE_ST_IDLE;
            wait_q <= 8'h00;
            hi_q   <= '0;
            sym_q  <= '{default: tre_pkg::TRE_SYM_LOW};
            idx_q  <= 5'h00;
            word_q <= 2'h0;
            bias_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            wait_q <= wait_d;
            hi_q   <= hi_d;
            sym_q  <= sym_d;
            idx_q  <= idx_d;
            word_q <= word_d;
            bias_q <= bias_d;
        end
    end
    assign sense_bias = bias_q;

    // ----------------------------------------------------------------------
    // symbol buffer
    // ----------------------------------------------------------------------
    tre_sym_buf #(
        .DEPTH (`TRE_BUF_DEPTH)
    ) u_buf (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .in_s    (push_if.snk),
        .out_s   (pop_if.src)
    );

    // ----------------------------------------------------------------------
    // serialiser: eight ticks per symbol
    // ----------------------------------------------------------------------
    logic [7:0] shr_q, shr_d;
    logic [2:0] bit_q, bit_d;
    logic       busy_q, busy_d;
    logic [7:0] pat;

    // low pattern a quarter high, high three quarters, float and sync exactly half
    always_comb
    begin
        unique case (pop_if.data)
            tre_pkg::TRE_SYM_LOW:   pat = `TRE_PAT_LOW;
            tre_pkg::TRE_SYM_HIGH:  pat = `TRE_PAT_HIGH;
            tre_pkg::TRE_SYM_FLOAT: pat = `TRE_PAT_FLOAT;
            tre_pkg::TRE_SYM_SYNC:  pat = `TRE_PAT_SYNC;
        endcase
    end

    assign pop_if.ready = tick && (!busy_q || bit_q == 3'h0);
    assign ser_idle     = !busy_q && !pop_if.valid;

    // register cleared while idle so the keying output rests low
    always_comb
    begin
        shr_d  = shr_q;
        bit_d  = bit_q;
        busy_d = busy_q;
        if (tick)
        begin
            if (busy_q && bit_q != 3'h0)
            begin
                shr_d = {shr_q[6:0], 1'b0};
                bit_d = bit_q - 3'h1;
            end
            else if (pop_if.valid)
            begin
                shr_d  = pat;
                bit_d  = 3'h7;
                busy_d = 1'b1;
            end
            else
            begin
                shr_d  = 8'h00;
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            shr_q  <= 8'h00;
            bit_q  <= 3'h0;
            busy_q <= 1'b0;
        end
        else
        begin
            shr_q  <= shr_d;
            bit_q  <= bit_d;
            busy_q <= busy_d;
        end
    end
    assign serial_mod_out = shr_q[7];

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    logic [22:0] lag_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || st_q == tre_pkg::TRE_ST_SENSL)
            lag_q <= 23'h000000;
        else if (st_q != tre_pkg::TRE_ST_IDLE && lag_q != 23'h7FFFFF)
            lag_q <= lag_q + 23'h000001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_start_on_trig: assert property (st_q == tre_pkg::TRE_ST_IDLE && trig_s |=>
        st_q == tre_pkg::TRE_ST_SENSH && bias_q) else $error("trigger did not start a cycle");
    a_restart_cycle: assert property (last_push && trig_s |=>
        st_q == tre_pkg::TRE_ST_SENSH) else $error("cycle not restarted");
    a_finish_stop: assert property (last_push && !trig_s |=>
        st_q == tre_pkg::TRE_ST_DRAIN) else $error("cycle not finished on trigger low");
    a_symbol_order: assert property (push_if.valid && push_if.ready && idx_q != 5'(NS) |=>
        idx_q == $past(idx_q) + 5'h01) else $error("symbol out of order");
    a_float_sensed: assert property (st_q == tre_pkg::TRE_ST_SENSL && st_d == tre_pkg::TRE_ST_SEND
        && hi_q[0] != lines_s[0] |=> sym_q[0] == tre_pkg::TRE_SYM_FLOAT)
        else $error("floating line not sensed");
    a_bias_sequence: assert property ($rose(st_q == tre_pkg::TRE_ST_SENSL) |->
        !bias_q && $past(bias_q)) else $error("sense bias out of step");
    a_lag_bound: assert property (lag_q < 23'(LAG_CYC))
        else $error("cycle longer than allowed lag");
    a_tick_period: assert property (tick |=> !tick [*8])
        else $error("oscillator tick too frequent");
    a_idle_quiet: assert property (st_q == tre_pkg::TRE_ST_IDLE && !busy_q |->
        !serial_mod_out) else $error("keying active while idle");

    c_start:   cover property (st_q == tre_pkg::TRE_ST_IDLE ##1 st_q == tre_pkg::TRE_ST_SENSH);
    c_restart: cover property (last_push && trig_s);
    c_drain:   cover property (st_q == tre_pkg::TRE_ST_DRAIN ##1 st_q == tre_pkg::TRE_ST_IDLE);

endmodule

`default_nettype wire

/* testbench/tre_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tre_cfg.svh"

// receiver side: times keyed symbols, checks the address, mirrors the data
module tre_rx_model #(
    parameter logic [19:0] LOCAL_ADDR = 20'h00000
) (
    // clock
    input  wire logic        ref_clk,
    // keyed line from the encoder
    input  wire logic        serial_mod_out,
    // decoded results
    output logic [7:0]       rx_data,
    output logic [37:0]      rx_word,
    output int               rx_hits,
    output int               rx_words,
    output int               rx_bad
);
    localparam int TICK = `TRE_OSC_DIV;

    // --------------------------------------------------------------
    // symbol decoder
    // --------------------------------------------------------------
    // every pattern opens high and closes low, so each symbol starts on
    // a rising edge; bits are taken mid-tick to ride out edge jitter
    initial
    begin
        logic [7:0]        pat;
        tre_pkg::tre_sym_e sym;
        int                n;
        rx_data  = 8'h00;
        rx_word  = '0;
        rx_hits  = 0;
        rx_words = 0;
        rx_bad   = 0;
        n        = 0;
        forever
        begin
            @(posedge serial_mod_out);
            repeat (TICK / 2) @(posedge ref_clk);
            for (int k = 7; k >= 0; k--)
            begin
                pat[k] = serial_mod_out;
                if (k > 0)
                    repeat (TICK) @(posedge ref_clk);
            end
            case (pat)
                `TRE_PAT_LOW:   sym = tre_pkg::TRE_SYM_LOW;
                `TRE_PAT_HIGH:  sym = tre_pkg::TRE_SYM_HIGH;
                `TRE_PAT_FLOAT: sym = tre_pkg::TRE_SYM_FLOAT;
                `TRE_PAT_SYNC:  sym = tre_pkg::TRE_SYM_SYNC;
                default:
                begin
                    sym = tre_pkg::TRE_SYM_SYNC;
                    rx_bad++;
                end
            endcase
            if (n < 19)
                rx_word[2*n +: 2] = sym;
            n++;
            if (sym == tre_pkg::TRE_SYM_SYNC)
            begin
                rx_words++;
                if (n != 19)
                    rx_bad++;
                else if (rx_word[19:0] == LOCAL_ADDR)
                begin
                    rx_hits++;
                    // floating data reads low: outputs have two levels only
                    for (int i = 0; i < 8; i++)
                        rx_data[i] = (rx_word[20+2*i +: 2] == tre_pkg::TRE_SYM_HIGH);
                end
                n = 0;
            end
        end
    end
endmodule

`default_nettype wire

/* testbench/tristate_remote_encoder_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tre_cfg.svh"

module tristate_remote_encoder_bench;
    // --------------------------------------------------------------
    // line settings and expected word
    // --------------------------------------------------------------
    localparam logic [9:0] A_LVL = 10'h2A4;
    localparam logic [9:0] A_FLT = 10'h0C3;
    localparam logic [7:0] D_LVL = 8'hDB;
    localparam logic [7:0] D_FLT = 8'h81;
    localparam int         TICK  = `TRE_OSC_DIV;

    // symbol code of each line: floating, else its level
    function automatic logic [19:0] line_code(input logic [9:0] lvl, input logic [9:0] flt);
        logic [19:0] c;
        for (int i = 0; i < 10; i++)
            c[2*i +: 2] = flt[i] ? tre_pkg::TRE_SYM_FLOAT :
                          (lvl[i] ? tre_pkg::TRE_SYM_HIGH : tre_pkg::TRE_SYM_LOW);
        return c;
    endfunction

    localparam logic [19:0] A_CODE = line_code(A_LVL, A_FLT);
    localparam logic [19:0] D_CODE = line_code({2'h0, D_LVL}, {2'h0, D_FLT});
    localparam logic [37:0] W_EXP  = {tre_pkg::TRE_SYM_SYNC, D_CODE[15:0], A_CODE};

    logic        ref_clk;
    logic        rst_n;
    logic        transmit_trigger_line;
    logic        sense_bias;
    logic        serial_mod_out;
    logic [9:0]  a_lvl;
    logic [7:0]  d_lvl;
    logic [9:0]  pairing_code_inputs;
    logic [7:0]  payload_inputs;
    logic [7:0]  rx_data;
    logic [37:0] rx_word;
    int          rx_hits;
    int          rx_words;
    int          rx_bad;
    int          other_hits;
    int          err_count;
    int          samples_checked;
    int          hi_cyc;
    int          all_cyc;

    // floating pins follow the weak bias, driven pins ignore it
    assign pairing_code_inputs = (a_lvl & ~A_FLT) | ({10{sense_bias}} & A_FLT);
    assign payload_inputs      = (d_lvl & ~D_FLT) | ({8{sense_bias}} & D_FLT);

    // --------------------------------------------------------------
    // design and two receivers, one with a wrong address
    // --------------------------------------------------------------
    tre_encoder #(.LAG_CYC(200000)) i_tre_encoder (
        .ref_clk               (ref_clk),
        .rst_n                 (rst_n),
        .transmit_trigger_line (transmit_trigger_line),
        .pairing_code_inputs   (pairing_code_inputs),
        .payload_inputs        (payload_inputs),
        .sense_bias            (sense_bias),
        .serial_mod_out        (serial_mod_out)
    );
    tre_rx_model #(.LOCAL_ADDR(A_CODE)) i_tre_rx_model (
        .ref_clk (ref_clk), .serial_mod_out (serial_mod_out), .rx_data (rx_data),
        .rx_word (rx_word), .rx_hits (rx_hits), .rx_words (rx_words), .rx_bad (rx_bad)
    );
    // line 0 floats; this receiver expects it low
    tre_rx_model #(.LOCAL_ADDR(A_CODE ^ 20'h00003)) i_tre_rx_model_other (
        .ref_clk (ref_clk), .serial_mod_out (serial_mod_out), .rx_data (),
        .rx_word (), .rx_hits (other_hits), .rx_words (), .rx_bad ()
    );

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded wait for decoded words; also tallies keying duty
    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (rx_words < n && k < 60000)
        begin
            @(negedge ref_clk);
            hi_cyc += serial_mod_out;
            all_cyc++;
            k++;
        end
        if (rx_words < n)
        begin
            err_count++;
            $display("[ERR] %0t ns: no word decoded in time", $time);
            end_of_test();
        end
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // no trigger: no sensing and no keying
    task automatic t_idle();
        int hi;
        hi = 0;
        repeat (1000)
        begin
            @(negedge ref_clk);
            if (sense_bias !== 1'b0 || serial_mod_out !== 1'b0)
                hi++;
        end
        check(hi, 0, "activity without trigger");
    endtask

    // trigger rise: bias phases, then first keyed bit on an oscillator tick
    task automatic t_start();
        int k;
        @(negedge ref_clk);
        transmit_trigger_line = 1'b1;
        k = 0;
        while (sense_bias !== 1'b1 && k < 20)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check(k, 3, "bias delay");
        if (k >= 20)
            end_of_test();
        k = 0;
        while (sense_bias === 1'b1 && k < 1000)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check(k, `TRE_SETTLE_CYC, "bias width");
        if (k >= 1000)
            end_of_test();
        k = 0;
        while (serial_mod_out !== 1'b1 && k < 2000)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check(k >= 250 && k <= 251 + TICK, 1'b1, "first keying");
        if (k >= 2000)
            end_of_test();
    endtask

    // first word; data change and trigger drop land mid-word
    task automatic t_word1();
        repeat (20 * TICK) @(negedge ref_clk);
        d_lvl = 8'h24;
        transmit_trigger_line = 1'b0;
        wait_words(1);
        check(rx_word, W_EXP, "word one");
        check(rx_bad, 0, "bad symbols");
        check(rx_hits, 1, "address match");
        check(other_hits, 0, "float read as low");
        check(rx_data, D_LVL & ~D_FLT, "mirrored data");
    endtask

    // second word still sent after trigger fell, with captured data
    task automatic t_word2();
        hi_cyc  = 0;
        all_cyc = 0;
        wait_words(2);
        check(rx_word, W_EXP, "word two");
        check(rx_hits, 2, "second match");
        check(hi_cyc * 100 >= all_cyc * 40 && hi_cyc * 100 <= all_cyc * 60, 1'b1,
              "keying duty");
    endtask

    // reset mid-cycle quiets outputs; low trigger starts nothing new
    task automatic t_reset();
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({sense_bias, serial_mod_out}, 2'b00, "outputs in reset");
        rst_n = 1'b1;
        repeat (600) @(negedge ref_clk);
        check({sense_bias, serial_mod_out}, 2'b00, "quiet after reset");
    endtask

    // --------------------------------------------------------------
    // clock and main sequence
    // --------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #(`TRE_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    initial
    begin
        rst_n                 = 1'b0;
        transmit_trigger_line = 1'b0;
        a_lvl                 = A_LVL;
        d_lvl                 = D_LVL;
        err_count             = 0;
        samples_checked       = 0;
        hi_cyc                = 0;
        all_cyc               = 0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        t_idle();
        t_start();
        t_word1();
        t_word2();
        t_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
